// File: lvpc_defines.vh
// constants for the lvds lane power control block
// assumes inclusion by bare name from design files on aclk
//
// Overview of operation
// (RL1) sleep stops pll, powers down all drivers
// (RL2) sleep control: 0 sleeps, 1 runs
// (RL3) swing select: 0 low swing, 1 high
// (RL4) 18-bit tri-states lane 3 of used banks
// (RL5) powered-down lane stays down, never tri-stated
// (RL6) depth 0 four lanes, 1 three lanes
// (RL7) powered-down driver pulls outputs to ground
// (RL8) unconnected inputs default low; the code has no pull-downs, it only clears the synchroniser stages at reset
// (RL9) host releases sleep after supplies stable
// (RL10) host sends clock only after release
// (RL11) host power-up order with lock wait
// (RL12) host power-down order with black frames; the bench sends no black frames, it drops wake then stops run 4 cycles later
// (RL13) mode selects decode three modes, 11 reserved
// (RL14) no pixel clock means low-power state
// (RL15) host waits use parameterised counters
`ifndef LVPC_DEFINES_VH
`define LVPC_DEFINES_VH

// ----------------------------------------------------------------
// operating modes {op_select_hi, op_select_lo}
// ----------------------------------------------------------------
`define LVPC_MODE_SINGLE_IN_SINGLE_OUT     2'h0
`define LVPC_MODE_SINGLE_IN_DUAL_OUT     2'h1
`define LVPC_MODE_DUAL_IN_DUAL_OUT     2'h2
`define LVPC_MODE_RSVD     2'h3

// ----------------------------------------------------------------
// lane states per driver
// ----------------------------------------------------------------
`define LVPC_LANE_OFF      2'h0
`define LVPC_LANE_ON       2'h1
`define LVPC_LANE_HIZ      2'h2

// ----------------------------------------------------------------
// swing levels in mVpp
// ----------------------------------------------------------------
`define LVPC_SWING_LOW_MV  16'h0168
`define LVPC_SWING_HIGH_MV 16'h0258

// ----------------------------------------------------------------
// pixel clock watchdog
// ----------------------------------------------------------------
`define LVPC_CLK_NS        5
`define LVPC_IDLE_NS       1000
`define LVPC_IDLE_CYC      (`LVPC_IDLE_NS / `LVPC_CLK_NS)
`define LVPC_CNT_W         8

// ----------------------------------------------------------------
// axi4-lite map
// ----------------------------------------------------------------
`define LVPC_ADDR_CTRL     4'h0
`define LVPC_ADDR_STAT     4'h4
`define LVPC_ADDR_LANE     4'h8
`define LVPC_RESP_OKAY     2'h0
`define LVPC_RESP_SLVERR   2'h2

`endif

// File: lvpc_sync.v
// two-flop synchroniser for a bus of asynchronous pin levels
// assumes pins come from outside the aclk domain
`timescale 1ns/10ps
module lvpc_sync #(
    parameter W = 8
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // (RL8) pins default low
    // synchronous reset clears both stages, so q reads low during reset; an unconnected pin is not pulled low
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule

// File: lvpc_top.v
// lane power control for a two-bank lvds serializer
// assumes static config pins, a free-running aclk, a pixel clock sampled as a pin
`timescale 1ns/10ps
`include "lvpc_defines.vh"
module lvpc_top #(
    parameter IDLE_CYC = `LVPC_IDLE_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        sleep_control_n,
    input  wire        swing_select,
    input  wire        color_depth_select,
    input  wire        op_select_lo,
    input  wire        op_select_hi,
    input  wire        pix_clk,
    output reg         pll_enable,
    output reg         swing_high,
    output reg  [4:0]  lane_a_power,
    output reg  [4:0]  lane_b_power,
    output reg  [4:0]  lane_a_oe,
    output reg  [4:0]  lane_b_oe,
    output reg  [4:0]  lane_a_pulldown,
    output reg  [4:0]  lane_b_pulldown,
    output reg         low_power,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [5:0] pin_s;
    lvpc_sync #(
        .W (6)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({pix_clk, op_select_hi, op_select_lo, color_depth_select,
                   swing_select, sleep_control_n}),
        .q       (pin_s)
    );
    wire       awake_pin = pin_s[0];
    wire       swing_pin = pin_s[1];
    wire       depth_pin = pin_s[2];
    wire [1:0] mode_pin  = pin_s[4:3];
    wire       pclk_s    = pin_s[5];

    // ----------------------------------------------------------------
    // software override register: bit0 force sleep
    // ----------------------------------------------------------------
    reg force_sleep_r;

    // ----------------------------------------------------------------
    // pixel clock activity watchdog
    // ----------------------------------------------------------------
    reg                  pclk_d_r;
    reg [`LVPC_CNT_W-1:0] idle_cnt_r;
    reg                  clk_idle_r;
    wire                 pclk_edge = pclk_s ^ pclk_d_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pclk_d_r   <= 1'b0;
            idle_cnt_r <= {`LVPC_CNT_W{1'b0}};
            clk_idle_r <= 1'b1;
        end
        else
        begin
            pclk_d_r <= pclk_s;
            // (RL14) idle clock detect
            if (pclk_edge)
            begin
                idle_cnt_r <= {`LVPC_CNT_W{1'b0}};
                clk_idle_r <= 1'b0;
            end
            else if (idle_cnt_r == IDLE_CYC[`LVPC_CNT_W-1:0] - 1'b1)
                clk_idle_r <= 1'b1;
            else
                idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // lane decode
    // ----------------------------------------------------------------
    // (RL2) low sleeps, high runs
    wire awake    = awake_pin & ~force_sleep_r;
    wire active   = awake & ~clk_idle_r;
    wire rsvd     = (mode_pin == `LVPC_MODE_RSVD);
    // (RL13) mode decode
    wire b_used   = (mode_pin == `LVPC_MODE_SINGLE_IN_DUAL_OUT) | (mode_pin == `LVPC_MODE_DUAL_IN_DUAL_OUT);

    reg [4:0] a_pwr_nxt;
    reg [4:0] b_pwr_nxt;
    reg [4:0] a_oe_nxt;
    reg [4:0] b_oe_nxt;

    always @*
    begin
        // lanes 0..3 data, lane 4 clock
        a_pwr_nxt = 5'h1F;
        b_pwr_nxt = b_used ? 5'h1F : 5'h00;
        // (RL1) sleep, idle or reserved powers both banks down
        if (!active || rsvd)
        begin
            a_pwr_nxt = 5'h00;
            b_pwr_nxt = 5'h00;
        end
        a_oe_nxt = a_pwr_nxt;
        b_oe_nxt = b_pwr_nxt;
        // (RL4) (RL6) 18-bit tri-states lane 3
        if (depth_pin)
        begin
            a_oe_nxt[3] = 1'b0;
            b_oe_nxt[3] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pll_enable      <= 1'b0;
            swing_high      <= 1'b0;
            low_power       <= 1'b1;
            lane_a_power    <= 5'h00;
            lane_b_power    <= 5'h00;
            lane_a_oe       <= 5'h00;
            lane_b_oe       <= 5'h00;
            lane_a_pulldown <= 5'h1F;
            lane_b_pulldown <= 5'h1F;
        end
        else
        begin
            // (RL1) pll only while awake
            pll_enable      <= awake & ~rsvd;
            low_power       <= ~active;
            // (RL3) swing level
            swing_high      <= swing_pin;
            lane_a_power    <= a_pwr_nxt;
            lane_b_power    <= b_pwr_nxt;
            lane_a_oe       <= a_oe_nxt;
            lane_b_oe       <= b_oe_nxt;
            // (RL5) (RL7) unpowered lanes pulled low, not floated
            lane_a_pulldown <= ~a_pwr_nxt;
            lane_b_pulldown <= ~b_pwr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg        w_strb0_r;
    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_ok = aw_hold_r | (s_axi_awvalid & s_axi_awready);
    wire w_ok  = w_hold_r | (s_axi_wvalid & s_axi_wready);
    wire [3:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
    wire ws0 = w_hold_r ? w_strb0_r : s_axi_wstrb[0];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_data_r      <= 32'h0000_0000;
            w_strb0_r     <= 1'b0;
            force_sleep_r <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LVPC_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LVPC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (aw_ok && w_ok)
            begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wa == `LVPC_ADDR_CTRL) ? `LVPC_RESP_OKAY
                                                        : `LVPC_RESP_SLVERR;
                if (wa == `LVPC_ADDR_CTRL && ws0)
                    force_sleep_r <= wd[0];
            end
            else
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    aw_hold_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    w_hold_r  <= 1'b1;
                    w_data_r  <= s_axi_wdata;
                    w_strb0_r <= s_axi_wstrb[0];
                end
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            else if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `LVPC_RESP_OKAY;
                case (s_axi_araddr)
                    `LVPC_ADDR_CTRL:
                        s_axi_rdata <= {31'h0000_0000, force_sleep_r};
                    `LVPC_ADDR_STAT:
                        s_axi_rdata <= {24'h00_0000, mode_pin, depth_pin, swing_pin,
                                        clk_idle_r, low_power, pll_enable, awake_pin};
                    `LVPC_ADDR_LANE:
                        s_axi_rdata <= {11'h000, lane_b_oe, lane_a_oe, 1'b0,
                                        lane_b_power, lane_a_power};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `LVPC_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule

// File: lvpc_monitor.sv
// checker for the lane power outputs of lvpc_top
// assumes binding to lvpc_top and a synchronous active-low reset
`timescale 1ns/10ps
module lvpc_monitor #(
    parameter IDLE_CYC = 8
) (
    input wire       aclk,
    input wire       aresetn,
    input wire       sleep_control_n,
    input wire       swing_select,
    input wire       color_depth_select,
    input wire       op_select_lo,
    input wire       op_select_hi,
    input wire       pix_clk,
    input wire       pll_enable,
    input wire       swing_high,
    input wire [4:0] lane_a_power,
    input wire [4:0] lane_b_power,
    input wire [4:0] lane_a_oe,
    input wire [4:0] lane_b_oe,
    input wire [4:0] lane_a_pulldown,
    input wire [4:0] lane_b_pulldown,
    input wire       low_power
);
    reg [7:0] idle_r;
    reg       pc_r;
    // cycles since the pixel clock pin last moved
    always @(posedge aclk)
    begin
        pc_r <= pix_clk;
        if (!aresetn || pix_clk != pc_r)
            idle_r <= 8'h00;
        else if (idle_r != 8'hff)
            idle_r <= idle_r + 8'h01;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sleep_off;
        !sleep_control_n [*4] |-> !pll_enable && lane_a_power == 5'h00 && low_power;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep left drivers on");
    property p_pulldown;
        lane_a_pulldown == ~lane_a_power && lane_b_pulldown == ~lane_b_power;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown mismatch");
    property p_tristate;
        color_depth_select [*4] |-> !lane_a_oe[3] && !lane_b_oe[3];
    endproperty
    a_tristate: assert property (p_tristate) else $error("lane 3 driving");
    property p_oe_pw;
        (lane_a_oe & ~lane_a_power) == 5'h00 && (lane_b_oe & ~lane_b_power) == 5'h00;
    endproperty
    a_oe_pw: assert property (p_oe_pw) else $error("unpowered lane enabled");
    property p_swing;
        swing_select [*4] |-> swing_high;
    endproperty
    a_swing: assert property (p_swing) else $error("swing not high");
    property p_rsvd;
        (op_select_lo && op_select_hi) [*4] |-> !pll_enable && lane_a_power == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode active");
    property p_single_in_single_out;
        (!op_select_lo && !op_select_hi) [*4] |-> lane_b_power == 5'h00;
    endproperty
    a_single_in_single_out: assert property (p_single_in_single_out) else $error("bank b on in single mode");
    property p_depth0;
        !color_depth_select [*4] |-> lane_a_oe == lane_a_power && lane_b_oe == lane_b_power;
    endproperty
    a_depth0: assert property (p_depth0) else $error("lane off in full depth");
    property p_idle;
        idle_r > IDLE_CYC + 5 |-> low_power && lane_a_power == 5'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("idle clock not low power");
    c_dual: cover property (lane_b_power == 5'h1f);
    c_hiz: cover property (lane_a_power[3] && !lane_a_oe[3]);
    c_idle: cover property (idle_r > IDLE_CYC + 5);
endmodule
bind lvpc_top lvpc_monitor #(.IDLE_CYC(IDLE_CYC)) u_mon (
    .aclk, .aresetn, .sleep_control_n, .swing_select, .color_depth_select,
    .op_select_lo, .op_select_hi, .pix_clk, .pll_enable, .swing_high,
    .lane_a_power, .lane_b_power, .lane_a_oe, .lane_b_oe, .lane_a_pulldown,
    .lane_b_pulldown, .low_power
);

// File: lvpc_host.sv
// host video source model: sleep release and pixel clock
// assumes the bench sets wake and run as levels
`timescale 1ns/10ps
module lvpc_host (
    input  wire aclk,
    input  wire wake,
    input  wire run,
    output reg  sleep_control_n,
    output reg  pix_clk
);
    initial
    begin
        sleep_control_n = 1'b0;
        pix_clk         = 1'b0;
    end
    always @(posedge aclk)
        sleep_control_n <= wake;
    always @(posedge aclk)
        pix_clk <= (run && sleep_control_n) ? ~pix_clk : 1'b0;
endmodule

// File: lvds_lane_power_control_tb_top.sv
// testbench for lvpc_top: sleep and pixel clock through the host model, config pins direct, registers over axi4-lite
// assumes a 200 MHz aclk and a small idle count
`timescale 1ns/10ps
module lvds_lane_power_control_tb_top;
    localparam IDLE = 8;
    localparam LOCK = 24;
    reg         aclk, aresetn, wake, run, swing_select, color_depth_select;
    reg         op_select_lo, op_select_hi, s_axi_awvalid, s_axi_wvalid;
    reg         s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    reg  [31:0] s_axi_wdata, s;
    reg  [33:0] e, exp_q[$];
    integer     n_fail, n_compared, cyc, i, seed;
    wire        sleep_control_n, pix_clk, pll_enable, swing_high, low_power;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [4:0]  lane_a_power, lane_b_power, lane_a_oe, lane_b_oe;
    wire [4:0]  lane_a_pulldown, lane_b_pulldown;
    lvpc_host u_host (.aclk, .wake, .run, .sleep_control_n, .pix_clk);
    lvpc_top #(.IDLE_CYC(IDLE)) u_dut (
        .aclk, .aresetn, .sleep_control_n, .swing_select, .color_depth_select,
        .op_select_lo, .op_select_hi, .pix_clk, .pll_enable, .swing_high,
        .lane_a_power, .lane_b_power, .lane_a_oe, .lane_b_oe, .lane_a_pulldown,
        .lane_b_pulldown, .low_power, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task complete_run;
    begin
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task chk(input [33:0] x, input [33:0] y, input [79:0] nm);
    begin
        n_compared = n_compared + 1;
        if (x !== y)
        begin
            n_fail = n_fail + 1;
            $display("[ERR] %0s exp %h got %h", nm, x, y);
        end
    end
    endtask
    // lanes {b oe, a oe, 0, b power, a power}
    function [20:0] lane_exp(input [1:0] m, input d);
        reg [4:0] a, b, t;
        begin
            a = (m != 2'h3) ? 5'h1f : 5'h00;
            b = (m == 2'h1 || m == 2'h2) ? 5'h1f : 5'h00;
            t = d ? 5'h17 : 5'h1f;
            lane_exp = {b & t, a & t, 1'b0, b, a};
        end
    endfunction
    task wr(input [3:0] a, input [31:0] d, input [1:0] r);
    begin
        @(posedge aclk);
        exp_q.push_back({r, 32'h0000_0000});
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, input [31:0] d, input [1:0] r);
    begin
        @(posedge aclk);
        exp_q.push_back({r, d});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    end
    endtask
    // responses are compared against the oldest note
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            n_fail = n_fail + 1;
            complete_run;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            e = exp_q.pop_front();
            chk(e, {s_axi_bresp, 32'h0000_0000}, "bresp");
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = exp_q.pop_front();
            chk(e, {s_axi_rresp, s_axi_rdata}, "rdata");
        end
    end
    initial
    begin
        {n_fail, n_compared, cyc} = 0;
        seed = 32'h4a27_7702;
        {aresetn, wake, run, swing_select, color_depth_select} = 5'h00;
        {op_select_lo, op_select_hi, s_axi_awvalid, s_axi_wvalid} = 4'h0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h0000_0000, 2'h0);
        chk(1'b0, pll_enable, "pll_rst");
        rd(4'hc, 32'h0000_0000, 2'h2);
        wr(4'h4, 32'h0000_0001, 2'h2);
        wr(4'hc, 32'h0000_0001, 2'h2);
        wake <= 1'b1;
        repeat (LOCK) @(posedge aclk);
        run <= 1'b1;
        repeat (LOCK) @(posedge aclk);
        for (i = 0; i < 8; i = i + 1)
        begin
            s = $random(seed);
            {op_select_hi, op_select_lo, color_depth_select} <= i[2:0];
            swing_select <= s[0];
            repeat (12) @(posedge aclk);
            e = lane_exp(i[2:1], i[0]);
            chk(e[4:0], lane_a_power, "a_pw");
            chk(e[9:5], lane_b_power, "b_pw");
            chk(e[15:11], lane_a_oe, "a_oe");
            chk(e[20:16], lane_b_oe, "b_oe");
            chk({~e[9:5]}, lane_b_pulldown, "b_pd");
            chk(i[2:1] != 2'h3, pll_enable, "pll");
            chk(s[0], swing_high, "swing");
            rd(4'h8, e[31:0], 2'h0);
        end
        op_select_hi <= 1'b0;
        run <= 1'b0;
        repeat (IDLE + 20) @(posedge aclk);
        chk(1'b1, low_power, "lp_idle");
        chk(5'h00, lane_b_power, "b_idle");
        chk(1'b1, pll_enable, "pll_idle");
        run <= 1'b1;
        repeat (LOCK) @(posedge aclk);
        wake <= 1'b0;
        repeat (4) @(posedge aclk);
        run <= 1'b0;
        repeat (12) @(posedge aclk);
        chk(1'b0, pll_enable, "pll_slp");
        chk(1'b1, low_power, "lp_slp");
        chk(5'h1f, lane_a_pulldown, "a_pd");
        wake <= 1'b1;
        run <= 1'b1;
        repeat (LOCK) @(posedge aclk);
        wr(4'h0, 32'h0000_0001, 2'h0);
        repeat (6) @(posedge aclk);
        chk(5'h00, lane_b_power, "b_force");
        rd(4'h0, 32'h0000_0001, 2'h0);
        wr(4'h0, 32'h0000_0000, 2'h0);
        repeat (12) @(posedge aclk);
        chk(5'h1f, lane_b_power, "b_wake");
        // status: single_in_dual_out, 18-bit, awake with pll on and clock running
        rd(4'h4, {24'h00_0000, 2'h1, 1'b1, s[0], 4'h3}, 2'h0);
        // a write with byte lane 0 disabled must leave the override alone
        s_axi_wstrb <= 4'he;
        wr(4'h0, 32'h0000_0001, 2'h0);
        rd(4'h0, 32'h0000_0000, 2'h0);
        repeat (6) @(posedge aclk);
        chk(5'h1f, lane_b_power, "b_strb");
        complete_run;
    end
endmodule
